// ==== logic/svm_pkg.sv ====
// constants of the supply voltage monitor
// How it works
// RULE_01: in run mode either path enable closes divider and activates selected features.
// RULE_02: stop mode opens divider and disables both sensing features regardless of enables.
// RULE_03: stop mode entry or exit never alters the configuration register.
// RULE_04: registers at indexes 0..3, indexes 4 and 5 read all zero.
// RULE_05: unimplemented bits of implemented registers always read zero.
// RULE_06: config bit 6 selects first or second high threshold for high comparator.
// RULE_07: config bits 5:4 select one of four low thresholds.
// RULE_08: config bit 3 closes divider and connects converter channel.
// RULE_09: config bit 2 closes divider and enables level sensing.
// RULE_10: after a path enable change the condition is invalid for settling plus two cycles.
// RULE_11: status register readable anytime, ignores writes, shows comparator results only.
// RULE_12: status bit 1 high while supply at or above selected high threshold.
// RULE_13: status bit 0 high while supply below selected low threshold.
// RULE_14: high irq enable gates high flag onto interrupt request.
// RULE_15: low irq enable gates low flag onto interrupt request.
// RULE_16: config and irq enable registers accept reads and writes at any time.
// RULE_17: a flag sets whenever its condition bit changes either way, stays set.
// RULE_18: flags clear only by writing one; zero has no effect.
// RULE_19: conditions forced to zero while sensing is disabled.
// RULE_20: enabled requests combine into one module interrupt output.
// RULE_21: comparator outputs synchronised before status update or change detection.
package svm_pkg;
  localparam logic [2:0] IDX_CONFIG   = 3'h0;
  localparam logic [2:0] IDX_STATUS   = 3'h1;
  localparam logic [2:0] IDX_IRQ_EN   = 3'h2;
  localparam logic [2:0] IDX_IRQ_FLAG = 3'h3;
  localparam logic [2:0] IDX_RSVD_LO  = 3'h4;
  localparam logic [2:0] IDX_RSVD_HI  = 3'h5;
  localparam int HIGH_SEL_BIT   = 6;
  localparam int LOW_SEL_LSB    = 4;
  localparam int CONV_EN_BIT    = 3;
  localparam int SENSE_EN_BIT   = 2;
  localparam int HIGH_BIT       = 1;
  localparam int LOW_BIT        = 0;
  localparam logic [7:0] CONFIG_MASK = 8'h7c;
  localparam logic [7:0] PAIR_MASK   = 8'h03;
  localparam logic [7:0] CONFIG_RST  = 8'h00;
  localparam logic [7:0] IRQ_EN_RST  = 8'h00;
  localparam logic [1:0] OKAY        = 2'h0;
  localparam logic [1:0] SLVERR      = 2'h2;
  localparam int SETTLE_BUS_CYCLES = 2;
endpackage

// ==== logic/svm_monitor.sv ====
// register and control logic of the supply voltage monitor
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module svm_monitor #(
  parameter int ADDR_W = 5
) (
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              stop_mode,
  input  wire logic              high_cmp_async,
  input  wire logic              low_cmp_async,
  output logic                   divider_close,
  output logic                   converter_connect,
  output logic                   sense_active,
  output logic                   high_level_select,
  output logic [1:0]             low_level_select,
  output logic                   module_irq
);
  if (ADDR_W < 5 || ADDR_W > 16) begin : g_addr_w_check
    $error("ADDR_W out of range");
  end

  logic [7:0]        config_q;
  logic [7:0]        irq_en_q;
  logic [1:0]        flags_q;
  logic [1:0]        sync1_q;
  logic [1:0]        sync2_q;
  logic [1:0]        cond_q;
  logic              aw_held_q;
  logic              w_held_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              do_write;
  logic              wr_hit;
  logic [2:0]        wr_idx;
  logic              wr_ok;
  logic [1:0]        cond_d;
  logic [1:0]        clear_bits;

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    addr_ok = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] <= (ADDR_W-2)'(svm_pkg::IDX_RSVD_HI));
  endfunction

  function automatic logic [2:0] addr_idx(input logic [ADDR_W-1:0] a);
    addr_idx = a[4:2];
  endfunction

  // write channel capture, either order
  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_idx   = addr_idx(awaddr_q);
  assign wr_ok    = addr_ok(awaddr_q);
  assign wr_hit   = do_write && wr_ok && wstrb_q[0];

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      aw_held_q     <= 1'b0;
      awaddr_q      <= '0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_q && !s_axi_awready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q     <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      w_held_q     <= 1'b0;
      wdata_q      <= '0;
      wstrb_q      <= '0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held_q && !s_axi_wready;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= svm_pkg::OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? svm_pkg::OKAY : svm_pkg::SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // configuration kept through stop mode
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      config_q <= svm_pkg::CONFIG_RST;
    end else if (wr_hit && wr_idx == svm_pkg::IDX_CONFIG) begin
      config_q <= wdata_q[7:0] & svm_pkg::CONFIG_MASK; // RULE_03 RULE_05 RULE_16
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq_en_q <= svm_pkg::IRQ_EN_RST;
    end else if (wr_hit && wr_idx == svm_pkg::IDX_IRQ_EN) begin
      irq_en_q <= wdata_q[7:0] & svm_pkg::PAIR_MASK; // RULE_05 RULE_16
    end
  end

  // analog path controls
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      divider_close     <= 1'b0;
      converter_connect <= 1'b0;
      sense_active      <= 1'b0;
      high_level_select <= 1'b0;
      low_level_select  <= 2'h0;
    end else begin
      divider_close     <= !stop_mode && (config_q[svm_pkg::CONV_EN_BIT] ||
                                          config_q[svm_pkg::SENSE_EN_BIT]); // RULE_01 RULE_02
      converter_connect <= !stop_mode && config_q[svm_pkg::CONV_EN_BIT]; // RULE_08 RULE_02
      sense_active      <= !stop_mode && config_q[svm_pkg::SENSE_EN_BIT]; // RULE_09 RULE_02
      high_level_select <= config_q[svm_pkg::HIGH_SEL_BIT]; // RULE_06
      low_level_select  <= config_q[svm_pkg::LOW_SEL_LSB +: 2]; // RULE_07
    end
  end

  // comparator synchroniser
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
    end else begin
      sync1_q <= {high_cmp_async, low_cmp_async}; // RULE_21
      sync2_q <= sync1_q; // RULE_21
    end
  end

  // conditions, forced low when sensing off
  assign cond_d = sense_active ? sync2_q : 2'h0; // RULE_19 RULE_12 RULE_13 RULE_10

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cond_q <= 2'h0;
    end else begin
      cond_q <= cond_d; // RULE_11
    end
  end

  // flags: set beats clear
  assign clear_bits = (wr_hit && wr_idx == svm_pkg::IDX_IRQ_FLAG) ? wdata_q[1:0] : 2'h0; // RULE_18

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      flags_q <= 2'h0;
    end else begin
      flags_q <= (flags_q & ~clear_bits) | (cond_d ^ cond_q); // RULE_17 RULE_18
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      module_irq <= 1'b0;
    end else begin
      module_irq <= |(flags_q & irq_en_q[1:0]); // RULE_14 RULE_15 RULE_20
    end
  end

  // read channel
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= svm_pkg::OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= addr_ok(s_axi_araddr) ? svm_pkg::OKAY : svm_pkg::SLVERR;
        unique case (addr_idx(s_axi_araddr))
          svm_pkg::IDX_CONFIG:   s_axi_rdata <= {24'h0, config_q}; // RULE_04
          svm_pkg::IDX_STATUS:   s_axi_rdata <= {30'h0, cond_q}; // RULE_11 RULE_05
          svm_pkg::IDX_IRQ_EN:   s_axi_rdata <= {24'h0, irq_en_q}; // RULE_04
          svm_pkg::IDX_IRQ_FLAG: s_axi_rdata <= {30'h0, flags_q}; // RULE_05
          default:               s_axi_rdata <= 32'h0; // RULE_04
        endcase
        if (!addr_ok(s_axi_araddr)) begin
          s_axi_rdata <= 32'h0;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // checks
  chk_stop_opens: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_02
    stop_mode |=> !divider_close && !sense_active && !converter_connect)
    else $error("path not opened in stop mode");
  chk_run_closes: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_01
    (!stop_mode && (config_q[2] || config_q[3])) |=> divider_close)
    else $error("divider not closed in run mode");
  chk_cfg_stable: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_03
    !(wr_hit && wr_idx == svm_pkg::IDX_CONFIG) |=> $stable(config_q))
    else $error("config changed without a write");
  chk_cond_off: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_19
    !sense_active |=> cond_q == 2'h0)
    else $error("condition not forced low");
  chk_sync_delay: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_21
    sense_active && $past(sense_active) |-> cond_q == $past(sync1_q, 2) || !$past(sense_active, 2))
    else $error("condition not two stages behind comparator");
  chk_flag_on_change: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_17
    $changed(cond_q) |-> flags_q == ($past(flags_q) & ~$past(clear_bits) | (cond_q ^ $past(cond_q))) &&
    ((cond_q ^ $past(cond_q)) & ~flags_q) == 2'h0)
    else $error("flag missed a condition change");
  chk_flag_hold: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_18
    (clear_bits == 2'h0 && cond_d == cond_q) |=> flags_q == $past(flags_q))
    else $error("flag changed without cause");
  chk_irq_gate: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_20
    ##1 module_irq == |($past(flags_q) & $past(irq_en_q[1:0])))
    else $error("interrupt output wrong");
  chk_high_mask: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_14
    (irq_en_q[1] && flags_q[1]) |=> module_irq)
    else $error("high request missing");
  chk_low_mask: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_15
    (irq_en_q[0] && flags_q[0]) |=> module_irq)
    else $error("low request missing");
  chk_rsvd_zero: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_05
    config_q[7] == 1'b0 && config_q[1:0] == 2'h0 && irq_en_q[7:2] == 6'h0)
    else $error("reserved bit set");
  chk_read_answer: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_16
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("read not answered");

  // analog path outputs
  chk_conv_path: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_08
    1'b1 |=> converter_connect == (!$past(stop_mode) && $past(config_q[svm_pkg::CONV_EN_BIT])))
    else $error("converter connect wrong");

  chk_sense_path: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_09
    1'b1 |=> sense_active == (!$past(stop_mode) && $past(config_q[svm_pkg::SENSE_EN_BIT])))
    else $error("sense enable wrong");

  chk_divider_off: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_01
    (!config_q[svm_pkg::SENSE_EN_BIT] && !config_q[svm_pkg::CONV_EN_BIT]) |=> !divider_close)
    else $error("divider closed with no enable");

  chk_high_select: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_06
    1'b1 |=> high_level_select == $past(config_q[svm_pkg::HIGH_SEL_BIT]))
    else $error("high level select wrong");

  chk_low_select: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_07
    1'b1 |=> low_level_select == $past(config_q[svm_pkg::LOW_SEL_LSB +: 2]))
    else $error("low level select wrong");

  // status and synchroniser
  chk_high_status: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_12
    sense_active |=> cond_q[svm_pkg::HIGH_BIT] == $past(sync2_q[1]))
    else $error("high condition wrong");

  chk_low_status: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_13
    sense_active |=> cond_q[svm_pkg::LOW_BIT] == $past(sync2_q[0]))
    else $error("low condition wrong");

  chk_sync_first: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_21
    1'b1 |=> sync2_q == $past(sync1_q))
    else $error("synchroniser stage skipped");

  chk_status_read: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_11
    (s_axi_arvalid && s_axi_arready && addr_ok(s_axi_araddr) && addr_idx(s_axi_araddr) == svm_pkg::IDX_STATUS)
    |=> s_axi_rdata == {30'h0, $past(cond_q)})
    else $error("status read wrong");

  // flags and interrupt
  chk_flag_high_set: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_17
    (cond_d[1] != cond_q[1]) |=> flags_q[1])
    else $error("high flag not set");

  chk_flag_low_set: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_17
    (cond_d[0] != cond_q[0]) |=> flags_q[0])
    else $error("low flag not set");

  chk_flag_sticky: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_17
    1'b1 |=> (($past(flags_q) & ~$past(clear_bits)) & ~flags_q) == 2'h0)
    else $error("flag dropped without clear");

  chk_flag_clear: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_18
    1'b1 |=> (flags_q & $past(clear_bits & ~(cond_d ^ cond_q))) == 2'h0)
    else $error("flag not cleared");

  chk_irq_off: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_20
    ((flags_q & irq_en_q[1:0]) == 2'h0) |=> !module_irq)
    else $error("interrupt without enabled flag");

  // register bus
  chk_cfg_write: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_16
    (wr_hit && wr_idx == svm_pkg::IDX_CONFIG) |=> config_q == ($past(wdata_q[7:0]) & svm_pkg::CONFIG_MASK))
    else $error("config write lost");

  chk_en_write: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_16
    (wr_hit && wr_idx == svm_pkg::IDX_IRQ_EN) |=> irq_en_q == ($past(wdata_q[7:0]) & svm_pkg::PAIR_MASK))
    else $error("enable write lost");

  chk_en_stable: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_16
    !(wr_hit && wr_idx == svm_pkg::IDX_IRQ_EN) |=> $stable(irq_en_q))
    else $error("enable changed without a write");

  chk_write_answer: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_16
    do_write |=> s_axi_bvalid)
    else $error("write not answered");

  chk_bvalid_hold: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_16
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
    else $error("write response dropped");

  chk_rvalid_hold: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_16
    (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped");

  chk_awready_busy: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_16
    aw_held_q |=> !s_axi_awready)
    else $error("address taken while busy");

  chk_wready_busy: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_16
    w_held_q |=> !s_axi_wready)
    else $error("data taken while busy");

  chk_arready_busy: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_16
    s_axi_rvalid |=> !s_axi_arready)
    else $error("read taken while busy");

  chk_bad_write: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_04
    (do_write && !wr_ok) |=> s_axi_bresp == svm_pkg::SLVERR)
    else $error("unmapped write not refused");

  chk_rsvd_read: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_04
    (s_axi_arvalid && s_axi_arready && addr_idx(s_axi_araddr) >= svm_pkg::IDX_RSVD_LO) |=> s_axi_rdata == 32'h0)
    else $error("reserved read not zero");

  chk_read_upper: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_05
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");

  cov_flag_high: cover property (@(posedge sys_clk) disable iff (!resetn) $rose(flags_q[1]));
  cov_irq: cover property (@(posedge sys_clk) disable iff (!resetn) $rose(module_irq));
  cov_stop: cover property (@(posedge sys_clk) disable iff (!resetn) $rose(stop_mode) && config_q[2]);
  cov_clear_set: cover property (@(posedge sys_clk) disable iff (!resetn) (clear_bits != 2'h0) && $changed(cond_d));
  cov_flag_low: cover property (@(posedge sys_clk) disable iff (!resetn) $rose(flags_q[0]));
endmodule

// ==== tb/svm_analog_model.sv ====
// behavioural model of the divider and the two level comparators
`timescale 1ns/1ps
module svm_analog_model (
  input  wire logic       divider_close,
  input  wire logic       sense_active,
  input  wire logic       high_level_select,
  input  wire logic [1:0] low_level_select,
  input  wire logic [7:0] supply_level,
  output logic            high_cmp_async,
  output logic            low_cmp_async
);
  logic       sensing;
  logic [7:0] high_trip;
  logic [7:0] low_trip;
  assign sensing        = divider_close & sense_active;
  assign high_trip      = high_level_select ? 8'hd0 : 8'hc0;
  assign low_trip       = 8'h40 + {2'h0, low_level_select, 4'h0};
  assign high_cmp_async = sensing & (supply_level >= high_trip);
  assign low_cmp_async  = sensing & (supply_level < low_trip);
endmodule

// ==== tb/tb_top.sv ====
// self-checking testbench of the supply voltage monitor
`timescale 1ns/1ps
module tb_top;
  logic        sys_clk = 1'h0;
  logic        resetn = 1'h0;
  logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        stop_mode = 1'h0;
  logic [7:0]  supply = 8'h80;
  logic        awready, wready, bvalid, arready, rvalid, hi_cmp, lo_cmp;
  logic        div_c, conv_c, sense_a, hi_sel, irq;
  logic [1:0]  bresp, rresp, lo_sel;
  int          fails = 0, samples_checked = 0, cyc = 0;

  always #50 sys_clk = ~sys_clk;

  svm_monitor dut_u (
    .sys_clk(sys_clk), .resetn(resetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .stop_mode(stop_mode), .high_cmp_async(hi_cmp), .low_cmp_async(lo_cmp),
    .divider_close(div_c), .converter_connect(conv_c), .sense_active(sense_a),
    .high_level_select(hi_sel), .low_level_select(lo_sel), .module_irq(irq)
  );

  svm_analog_model far_u (
    .divider_close(div_c), .sense_active(sense_a), .high_level_select(hi_sel),
    .low_level_select(lo_sel), .supply_level(supply),
    .high_cmp_async(hi_cmp), .low_cmp_async(lo_cmp)
  );

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
    chk("bresp", {30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] exp, input logic [1:0] er);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h0;
    chk("rdata", rdata, {24'h0, exp});
    chk("rresp", {30'h0, rresp}, {30'h0, er});
  endtask

  task automatic set_supply(input logic [7:0] v);
    @(posedge sys_clk);
    supply <= v;
    settle(8);
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    resetn <= 1'h1;
    for (int i = 0; i < 6; i++) rd(5'(4 * i), 8'h00, svm_pkg::OKAY);
    rd(5'h18, 8'h00, svm_pkg::SLVERR);
    wr(5'h00, 8'hff, svm_pkg::OKAY);
    rd(5'h00, 8'h7c, svm_pkg::OKAY);
    wr(5'h08, 8'hff, svm_pkg::OKAY);
    rd(5'h08, 8'h03, svm_pkg::OKAY);
    settle(3);
    chk("outs", {26'h0, div_c, conv_c, sense_a, hi_sel, lo_sel}, 32'h3f);
    @(posedge sys_clk);
    stop_mode <= 1'h1;
    settle(3);
    chk("stop", {29'h0, div_c, conv_c, sense_a}, 32'h0);
    rd(5'h00, 8'h7c, svm_pkg::OKAY);
    @(posedge sys_clk);
    stop_mode <= 1'h0;
    settle(3);
    chk("resume", {26'h0, div_c, conv_c, sense_a, hi_sel, lo_sel}, 32'h3f);
    wr(5'h00, 8'h14, svm_pkg::OKAY);
    settle(3);
    chk("paths", {29'h0, div_c, conv_c, sense_a}, 32'h5);
    wr(5'h00, 8'h08, svm_pkg::OKAY);
    settle(3);
    chk("paths", {29'h0, div_c, conv_c, sense_a}, 32'h6);
    for (int j = 0; j < 4; j++) begin
      wr(5'h00, {2'h0, 2'(j), 4'h4}, svm_pkg::OKAY);
      settle(3);
      chk("low select", {30'h0, lo_sel}, 32'(j));
    end
    wr(5'h08, 8'h00, svm_pkg::OKAY);
    wr(5'h0c, 8'h03, svm_pkg::OKAY);
    wr(5'h00, 8'h14, svm_pkg::OKAY);
    set_supply(8'h45);
    rd(5'h04, 8'h01, svm_pkg::OKAY);
    rd(5'h0c, 8'h01, svm_pkg::OKAY);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(5'h08, 8'h01, svm_pkg::OKAY);
    settle(2);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(5'h0c, 8'h00, svm_pkg::OKAY);
    rd(5'h0c, 8'h01, svm_pkg::OKAY);
    wr(5'h04, 8'hff, svm_pkg::OKAY);
    rd(5'h04, 8'h01, svm_pkg::OKAY);
    wr(5'h0c, 8'h01, svm_pkg::OKAY);
    settle(2);
    rd(5'h0c, 8'h00, svm_pkg::OKAY);
    chk("irq", {31'h0, irq}, 32'h0);
    set_supply(8'hc8);
    rd(5'h04, 8'h02, svm_pkg::OKAY);
    rd(5'h0c, 8'h03, svm_pkg::OKAY);
    wr(5'h08, 8'h02, svm_pkg::OKAY);
    wr(5'h0c, 8'h01, svm_pkg::OKAY);
    settle(2);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(5'h00, 8'h54, svm_pkg::OKAY);
    settle(8);
    rd(5'h04, 8'h00, svm_pkg::OKAY);
    wr(5'h00, 8'h14, svm_pkg::OKAY);
    settle(8);
    wr(5'h0c, 8'h03, svm_pkg::OKAY);
    wr(5'h00, 8'h10, svm_pkg::OKAY);
    settle(8);
    rd(5'h04, 8'h00, svm_pkg::OKAY);
    rd(5'h0c, 8'h02, svm_pkg::OKAY);
    wr(5'h10, 8'hff, svm_pkg::OKAY);
    rd(5'h10, 8'h00, svm_pkg::OKAY);
    wr(5'h18, 8'hff, svm_pkg::SLVERR);
    close_out();
  end
endmodule
